// [verilog/bpm_pkg.sv]
// Purpose: Shared constants for the bus pin function mux
// Assumes: Single 125 MHz clock domain, synchronous reset
// Notes:   Bus states count from one; third_bus_state is the switch point
package bpm_pkg;
	localparam logic [2:0] MODE_MIN_EXP   = 3'h1;
	localparam logic [2:0] MODE_MAX_FIXED = 3'h4;
	localparam logic [2:0] MODE_DDR_SEL   = 3'h5;
	localparam logic [1:0] THIRD_STATE    = 2'h3;
	localparam logic [7:0] LATCH_RST      = 8'h00;
	localparam logic [7:0] DIR_RST        = 8'h00;
	localparam logic [2:0] ACC_RST        = 3'h0;
	localparam logic [2:0] BUS_REQUEST_N_HI_MIN    = 3'h3;
	localparam logic [1:0] BUS_REQUEST_N_HI_SAMP   = 2'h2;
	typedef enum logic [1:0] {
		BPM_ARB_CPU  = 2'b00,
		BPM_ARB_WAIT = 2'b01,
		BPM_ARB_REL  = 2'b10
	} bpm_arb_t;
endpackage

// [verilog/bpm_pin_mux.sv]
// Purpose: Port pin function selection and external bus release arbiter
// Assumes: Software writes arrive as a register index plus data with a strobe
// Notes:   Only low address ports, cs0 and A23..A20 are muxed here
//
// Operation
// - Bus config writes apply at the next cycle boundary
// - Chip-select direction switch applies at third state
// - Upper address switch applies at third state
// - Per-pin direction and output latch registers
// - Ports 2, 4, 5 have pull-up control
// - Ten bidirectional ports plus input-only port
// - Low address pins follow mode and bus release
// - Chip-select 0 follows direction, mode reset default
// - Request sampled every clock, released at boundary
// - Released bus floats, ack low until two highs
`timescale 1ns/1ps
`default_nettype none
module bpm_pin_mux #(
	parameter int NPORT = 11
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic [2:0]        op_mode,
	input  wire logic              wr_en,
	input  wire logic [3:0]        wr_port,
	input  wire logic              wr_dir,
	input  wire logic [7:0]        wr_data,
	input  wire logic              bus_cfg_wr,
	input  wire logic [7:0]        bus_cfg_data,
	input  wire logic              rel_ctrl_wr,
	input  wire logic [4:0]        rel_ctrl_data,
	input  wire logic              pu_wr,
	input  wire logic [1:0]        pu_sel,
	input  wire logic [7:0]        pu_data,
	input  wire logic [1:0]        bus_state,
	input  wire logic              cycle_end,
	input  wire logic              bus_request_n,
	output logic [NPORT*8-1:0]     port_out,
	output logic [NPORT*8-1:0]     port_oe,
	output logic [23:0]            pullup_en,
	output logic [7:0]             bus_cfg_active,
	output logic [3:0]             upper_addr_en,
	output logic                   cs0_out_en,
	output logic                   addr_low_oe,
	output logic                   bus_float,
	output logic                   bus_ack_n
);
	// Port 7 is input only; index 6 counts ports 1..6,7,8,9,A,B
	localparam int P7 = 6;

	typedef struct packed {
		logic [NPORT*8-1:0] dir;
		logic [NPORT*8-1:0] latch;
		logic [23:0]        pu;
		logic [7:0]         cfg_pend;
		logic               cfg_dirty;
		logic [7:0]         cfg_act;
		logic [4:0]         rel_pend;
		logic               rel_dirty;
		logic [4:0]         rel_act;
		logic               dir_dirty;
		logic [NPORT*8-1:0] oe;
		logic [NPORT*8-1:0] out;
		logic [3:0]         up_en;
		logic               cs0_en;
		logic               alo;
		logic               flt;
		logic               ack_n;
		logic               rq_s1;
		logic               rq_s2;
		logic [1:0]         hi_cnt;
		logic               started;
		bpm_pkg::bpm_arb_t  arb;
	} bpm_state_t;

	bpm_state_t st_q;
	bpm_state_t st_d;

	// Expanded mode with fixed address outputs
	function automatic logic fixed_mode(input logic [2:0] m);
		fixed_mode = (m >= bpm_pkg::MODE_MIN_EXP) && (m <= bpm_pkg::MODE_MAX_FIXED);
	endfunction

	always_comb
	begin
		st_d = st_q;
		// Two-flop synchroniser on the request pin
		st_d.rq_s1 = bus_request_n;
		st_d.rq_s2 = st_q.rq_s1;
		// Latch and direction writes; port 7 has no output drive
		if (wr_en && (int'(wr_port) < NPORT) && (int'(wr_port) != P7))
		begin
			if (wr_dir)
			begin
				st_d.dir[wr_port*8 +: 8] = wr_data;
				st_d.dir_dirty = 1'b1;
			end
			else
				st_d.latch[wr_port*8 +: 8] = wr_data;
		end
		// Pull-up banks for ports 2, 4, 5
		if (pu_wr && (pu_sel < 2'h3))
			st_d.pu[pu_sel*8 +: 8] = pu_data;
		// Bus config waits for the cycle boundary
		if (bus_cfg_wr)
		begin
			st_d.cfg_pend = bus_cfg_data;
			st_d.cfg_dirty = 1'b1;
		end
		if (st_q.cfg_dirty && cycle_end)
		begin
			st_d.cfg_act = st_q.cfg_pend;
			st_d.cfg_dirty = bus_cfg_wr;
		end
		if (rel_ctrl_wr)
		begin
			st_d.rel_pend = rel_ctrl_data;
			st_d.rel_dirty = 1'b1;
		end
		// Pin function changes land at the third state of the write
		if (st_q.rel_dirty && (bus_state == bpm_pkg::THIRD_STATE))
		begin
			st_d.rel_act = st_q.rel_pend;
			st_d.rel_dirty = rel_ctrl_wr;
		end
		if (st_q.dir_dirty && (bus_state == bpm_pkg::THIRD_STATE))
		begin
			st_d.cs0_en = fixed_mode(op_mode) || (op_mode == bpm_pkg::MODE_DDR_SEL)
				? st_q.dir[7*8+4] : 1'b0;
			st_d.dir_dirty = wr_en && wr_dir;
		end
		// Arbiter: request sampled each edge, granted at a cycle boundary
		case (st_q.arb)
			bpm_pkg::BPM_ARB_CPU:
				if (st_q.rel_act[0] && !st_q.rq_s2)
					st_d.arb = bpm_pkg::BPM_ARB_WAIT;
			bpm_pkg::BPM_ARB_WAIT:
				if (cycle_end)
				begin
					st_d.arb = bpm_pkg::BPM_ARB_REL;
					st_d.ack_n = 1'b0;
					st_d.flt = 1'b1;
					st_d.hi_cnt = 2'h0;
				end
			bpm_pkg::BPM_ARB_REL:
			begin
				st_d.hi_cnt = st_q.rq_s2 ? ((st_q.hi_cnt == bpm_pkg::BUS_REQUEST_N_HI_SAMP) ?
					st_q.hi_cnt : st_q.hi_cnt + 2'h1) : 2'h0;
				if (st_d.hi_cnt == bpm_pkg::BUS_REQUEST_N_HI_SAMP)
				begin
					st_d.arb = bpm_pkg::BPM_ARB_CPU;
					st_d.ack_n = 1'b1;
					st_d.flt = 1'b0;
				end
			end
			default:
				st_d.arb = bpm_pkg::BPM_ARB_CPU;
		endcase
		if (!st_q.started)
		begin
			// Mode-dependent cs0 default caught after reset release
			st_d.started = 1'b1;
			st_d.dir[7*8+4] = fixed_mode(op_mode);
			st_d.cs0_en = fixed_mode(op_mode);
		end
		// Address pins float with the bus and come back when it is returned
		st_d.up_en = (st_d.rel_act[4] && !st_d.flt) ? st_d.rel_act[3:0] : 4'h0;
		st_d.alo = fixed_mode(op_mode) && !st_d.flt;
		// Output enables: released bus floats cs0; other port pins follow direction
		for (int i = 0; i < NPORT*8; i++)
		begin
			st_d.oe[i] = (i / 8 == P7) ? 1'b0 : st_q.dir[i];
			st_d.out[i] = (i / 8 == P7) ? 1'b0 : st_q.latch[i];
		end
		// Raw direction would switch cs0 early; the staged function waits for the third state
		if (fixed_mode(op_mode) || (op_mode == bpm_pkg::MODE_DDR_SEL))
			st_d.oe[7*8+4] = st_d.cs0_en;
		if (st_d.flt)
			st_d.oe[7*8+4] = 1'b0;
		if (sys_rst)
		begin
			st_d = '0;
			st_d.ack_n = 1'b1;
			st_d.rq_s1 = 1'b1;
			st_d.rq_s2 = 1'b1;
			st_d.arb = bpm_pkg::BPM_ARB_CPU;
		end
	end

	always_ff @(posedge ref_clk)
		st_q <= st_d;

	assign port_out = st_q.out;
	assign port_oe = st_q.oe;
	assign pullup_en = st_q.pu;
	assign bus_cfg_active = st_q.cfg_act;
	assign upper_addr_en = st_q.up_en;
	assign cs0_out_en = st_q.cs0_en;
	assign addr_low_oe = st_q.alo;
	assign bus_float = st_q.flt;
	assign bus_ack_n = st_q.ack_n;

	// Configuration only moves at a cycle boundary
	chk_cfg_boundary: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$changed(st_q.cfg_act) |-> $past(cycle_end)) else $error("cfg changed mid cycle");
	chk_ack_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!bus_ack_n |-> bus_float) else $error("ack low without float");
	chk_p7_no_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
		port_oe[P7*8 +: 8] == 8'h00) else $error("port 7 drives");
	chk_rel_third: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$changed(st_q.rel_act) |-> $past(bus_state) == bpm_pkg::THIRD_STATE)
		else $error("release ctrl off third state");
	chk_cs0_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bus_float |-> !port_oe[7*8+4]) else $error("cs0 driven while released");
	chk_addr_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bus_float |-> !addr_low_oe && (upper_addr_en == 4'h0))
		else $error("address driven while released");
	chk_cs0_staged: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!bus_float && st_q.started && (fixed_mode(op_mode) || (op_mode == bpm_pkg::MODE_DDR_SEL))
		|-> port_oe[7*8+4] == cs0_out_en)
		else $error("cs0 pin ahead of third state");
	sequence s_two_high;
		st_q.rq_s2 [*2];
	endsequence
	chk_ack_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.arb == bpm_pkg::BPM_ARB_REL) ##0 s_two_high |-> ##[0:1] bus_ack_n)
		else $error("ack not released");
	chk_grant_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(bus_ack_n) |-> $past(st_q.arb) == bpm_pkg::BPM_ARB_WAIT)
		else $error("grant skipped boundary");
	chk_dir_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_en && wr_dir && wr_port == 4'h0 && st_q.started |=> st_q.dir[7:0] == $past(wr_data))
		else $error("direction write lost");
endmodule
`default_nettype wire

// [tb/bpm_master_model.sv]
// Purpose: External bus master model driving the request pin
// Assumes: One request per go pulse
// Notes:   Wait for acknowledge is bounded so a dead arbiter cannot hang it
`timescale 1ns/1ps
`default_nettype none
module bpm_master_model (
	input  wire logic ref_clk,
	input  wire logic go,
	input  wire logic bus_ack_n,
	output logic      bus_request_n
);
	int n;
	// Request low until granted, then high long enough to end release
	initial
	begin
		bus_request_n = 1'b1;
		forever
		begin
			// Go is seen at a rising edge so the falling-edge race is avoided
			@(posedge ref_clk iff go);
			@(negedge ref_clk);
			bus_request_n = 1'b0;
			n = 0;
			while (bus_ack_n !== 1'b0 && n < 50)
			begin
				@(negedge ref_clk);
				n++;
			end // Held low until acknowledged
			repeat (4) @(negedge ref_clk);
			bus_request_n = 1'b1; // High for three states or more
			repeat (3) @(negedge ref_clk);
		end
	end
endmodule
`default_nettype wire

// [tb/bpm_pin_mux_bench.sv]
// Purpose: Self-checking bench for the pin function mux
// Assumes: Inputs change at the falling edge
// Notes:   Port tests run in mode 7 where pins are generic
`timescale 1ns/1ps
`default_nettype none
module bpm_pin_mux_bench;
	logic        ref_clk = 0, sys_rst = 1, wr_en = 0, wr_dir = 0, bus_cfg_wr = 0;
	logic        rel_ctrl_wr = 0, pu_wr = 0, cycle_end = 0, go = 0;
	logic [2:0]  op_mode = 3'h7;
	logic [3:0]  wr_port = 4'h0, upper_addr_en;
	logic [7:0]  wr_data = 8'h00, bus_cfg_data = 8'h00, pu_data = 8'h00, bus_cfg_active, a, b;
	logic [4:0]  rel_ctrl_data = 5'h00;
	logic [1:0]  pu_sel = 2'h0, bus_state = 2'h0;
	logic [87:0] port_out, port_oe;
	logic [23:0] pullup_en;
	logic        cs0_out_en, addr_low_oe, bus_float, bus_ack_n, bus_request_n;
	logic [31:0] seed = 32'h1552;
	int          errors = 0, checked = 0, n;
	// Clock of 8 ns
	always #4 ref_clk = ~ref_clk;
	bpm_pin_mux uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_mode(op_mode), .wr_en(wr_en),
		.wr_port(wr_port), .wr_dir(wr_dir), .wr_data(wr_data), .bus_cfg_wr(bus_cfg_wr),
		.bus_cfg_data(bus_cfg_data), .rel_ctrl_wr(rel_ctrl_wr), .rel_ctrl_data(rel_ctrl_data),
		.pu_wr(pu_wr), .pu_sel(pu_sel), .pu_data(pu_data), .bus_state(bus_state),
		.cycle_end(cycle_end), .bus_request_n(bus_request_n), .port_out(port_out),
		.port_oe(port_oe), .pullup_en(pullup_en), .bus_cfg_active(bus_cfg_active),
		.upper_addr_en(upper_addr_en), .cs0_out_en(cs0_out_en), .addr_low_oe(addr_low_oe),
		.bus_float(bus_float), .bus_ack_n(bus_ack_n));
	bpm_master_model mdl (.ref_clk(ref_clk), .go(go), .bus_ack_n(bus_ack_n),
		.bus_request_n(bus_request_n));
	function automatic logic [31:0] lf(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Modes 1 to 4 drive cs0 and the low address by default
	function automatic logic exp_fixed(input logic [2:0] m);
		return (m >= 3'h1) && (m <= 3'h4);
	endfunction
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e)
		begin
			errors++;
			$display("BAD t=%0t seen %h exp %h", $time, v, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask
	task automatic rst(input logic [2:0] m);
		op_mode = m;
		sys_rst = 1;
		cyc(8);
		sys_rst = 0;
		cyc(3);
	endtask
	// Latch or direction write, then let it reach the pins
	task automatic wr(input logic d, input logic [3:0] p, input logic [7:0] v);
		{wr_dir, wr_port, wr_data, wr_en} = {d, p, v, 1'b1};
		cyc(1);
		wr_en = 0;
		cyc(2);
	endtask
	task automatic end_sim;
		$display("counts errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard well beyond the planned run
	initial
	begin
		#100000;
		errors++;
		end_sim();
	end
	// Main sequence: ports, mode defaults, timed switches, release
	initial
	begin
		rst(3'h7);
		chk(bus_ack_n, 1);
		chk(port_oe[15:8], 0);
		for (n = 0; n < 4; n++)
		begin
			seed = lf(seed);
			a = seed[7:0];
			b = seed[15:8];
			wr(0, 4'h1, a);
			wr(1, 4'h1, b);
			chk({port_out[15:8], port_oe[15:8]}, {a, b});
			wr(1, 4'h0, a);
			chk(port_oe[7:0], a);
		end
		wr(0, 4'h6, 8'hFF);
		chk(port_out[55:48], 0);
		{pu_sel, pu_data, pu_wr} = {2'h0, a, 1'b1};
		cyc(1);
		{pu_sel, pu_data} = {2'h3, b};
		cyc(1);
		pu_wr = 0;
		cyc(2);
		chk(pullup_en, {16'h0, a});
		$display("test ports done");
		for (n = 2; n < 7; n++)
		begin
			rst(3'(n));
			chk({cs0_out_en, addr_low_oe}, {2{exp_fixed(3'(n))}});
		end
		rst(3'h5);
		chk({cs0_out_en, addr_low_oe}, 0);
		rst(3'h1);
		chk({cs0_out_en, addr_low_oe}, 3);
		$display("test modes done");
		{bus_cfg_data, bus_cfg_wr} = {b, 1'b1};
		cyc(1);
		bus_cfg_wr = 0;
		cyc(2);
		chk(bus_cfg_active, 0);
		cycle_end = 1;
		cyc(1);
		cycle_end = 0;
		cyc(1);
		chk(bus_cfg_active, b);
		{bus_state, rel_ctrl_data, rel_ctrl_wr} = {2'h1, 5'h1F, 1'b1};
		cyc(1);
		rel_ctrl_wr = 0;
		wr(1, 4'h7, 8'h00);
		chk({upper_addr_en, cs0_out_en}, 1);
		chk(port_oe[60], 1);
		bus_state = 2'h3;
		cyc(1);
		chk({upper_addr_en, cs0_out_en}, 5'h1E);
		chk(port_oe[60], 0);
		{bus_state, cycle_end, go} = {2'h0, 1'b1, 1'b1};
		cyc(1);
		go = 0;
		for (n = 0; n < 30 && bus_ack_n !== 1'b0; n++) cyc(1);
		chk(bus_float, 1);
		chk({upper_addr_en, addr_low_oe, port_oe[60]}, 0);
		for (n = 0; n < 30 && bus_ack_n !== 1'b1; n++) cyc(1);
		chk({bus_float, bus_ack_n}, 1);
		chk({upper_addr_en, addr_low_oe}, 5'h1F);
		$display("test release done");
		end_sim();
	end
endmodule
`default_nettype wire
